//--- core/iscd_frac_div.sv
`timescale 1ns/1ps
`default_nettype none
module iscd_frac_div #(
    parameter int NUM_W = 15,
    parameter int DEN_W = 9
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [NUM_W-1:0] num,
    input wire logic [DEN_W-1:0] den,
    output logic tick,
    output logic bit_clk
);
    localparam int ACC_W = NUM_W + 1;

    logic [ACC_W-1:0] acc_r;
    logic [ACC_W-1:0] acc_nxt;
    logic tick_r;
    logic tick_nxt;
    logic bit_clk_r;
    logic bit_clk_nxt;
    logic [ACC_W-1:0] sum;

    // ----------------------------------------
    // Fractional accumulation
    // ----------------------------------------
    // Average tick spacing is num/den cycles; a zero numerator stops the clock
    always_comb begin
        sum = acc_r + ACC_W'(den);
        acc_nxt = sum;
        tick_nxt = 1'b0;
        bit_clk_nxt = bit_clk_r;
        if (num == '0) begin
            acc_nxt = '0;
        end else if (sum >= ACC_W'(num)) begin
            acc_nxt = sum - ACC_W'(num);
            tick_nxt = 1'b1;
            bit_clk_nxt = ~bit_clk_r;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            acc_r <= '0;
            tick_r <= 1'b0;
            bit_clk_r <= 1'b0;
        end else begin
            acc_r <= acc_nxt;
            tick_r <= tick_nxt;
            bit_clk_r <= bit_clk_nxt;
        end
    end

    assign tick = tick_r;
    assign bit_clk = bit_clk_r;
endmodule
`default_nettype wire

//--- core/iscd_pkg.sv
// Overview of operation
// - Keep a 10-bit word counter; word count register shows low eight captured bits.
// - Any write to word count register captures the counter, then clears it.
// - Status bit 7 sets on transmit underflow, stays until software writes zero.
// - Status bit 6 sets on receive overflow, stays until software clears it.
// - Read-only status bit 5 names next transmit channel: zero left, one right.
// - Read-only status bit 4 names receive buffer channel: zero left, one right.
// - Status bit 3 transmit pending; software may set; sample high-byte write clears.
// - Status bit 2 receive pending; software may set; sample high-byte read clears.
// - Read-only status bits 1:0 show upper two captured counter bits.
// - Nine-bit denominator; low byte resets 0x93, top bit resets zero.
// - Fifteen-bit numerator; low byte resets 0xe2, upper seven bits reset 0x04.
// - Two-bit trigger select: register only, frame start, pin event, timer event.
// - Reading sample high byte empties receive buffer; writing it fills transmit buffer.
package iscd_pkg;

    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int CNT_W = 10;
    localparam int NUM_W = 15;
    localparam int DEN_W = 9;
    localparam int IRQ_W = 5;

    // Register addresses
    localparam logic [ADDR_W-1:0] ADDR_TRIG_CFG = 16'hdf41;
    localparam logic [ADDR_W-1:0] ADDR_SAMPLE_HIGH = 16'hdf43;
    localparam logic [ADDR_W-1:0] ADDR_WORD_COUNT_LOW = 16'hdf44;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 16'hdf45;
    localparam logic [ADDR_W-1:0] ADDR_DEN_LOW = 16'hdf46;
    localparam logic [ADDR_W-1:0] ADDR_NUM_LOW = 16'hdf47;
    localparam logic [ADDR_W-1:0] ADDR_DIV_HIGH = 16'hdf48;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 16'hdf50;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE = 16'hdf51;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_CLEAR = 16'hdf52;

    // Status register bit positions
    localparam int ST_TX_UNF = 7;
    localparam int ST_RX_OVF = 6;
    localparam int ST_TX_CH = 5;
    localparam int ST_RX_CH = 4;
    localparam int ST_TX_PEND = 3;
    localparam int ST_RX_PEND = 2;
    localparam int ST_CNT_HI = 0;

    // Trigger config field and divider high register layout
    localparam int TRIG_LSB = 1;
    localparam int DIV_DEN_TOP = 7;

    // Interrupt status bit positions
    localparam int IRQ_TX_UNF = 0;
    localparam int IRQ_RX_OVF = 1;
    localparam int IRQ_TX_PEND = 2;
    localparam int IRQ_RX_PEND = 3;
    localparam int IRQ_CAPTURE = 4;

    // Reset values
    localparam logic [DATA_W-1:0] RST_DEN_LOW = 8'h93;
    localparam logic [DATA_W-1:0] RST_NUM_LOW = 8'he2;
    localparam logic [6:0] RST_NUM_HIGH = 7'h04;
    localparam logic RST_DEN_TOP = 1'b0;

    typedef enum logic [1:0] {
        ISCD_TRIG_REG = 2'b00,
        ISCD_TRIG_SOF = 2'b01,
        ISCD_TRIG_PIN = 2'b10,
        ISCD_TRIG_TIMER = 2'b11
    } iscd_trig_t;

endpackage

//--- core/iscd_top.sv
`timescale 1ns/1ps
`default_nettype none
module iscd_top
    import iscd_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    // Register port
    input wire logic [iscd_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [iscd_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [iscd_pkg::DATA_W-1:0] reg_rdata,
    // Serial engine side
    input wire logic word_done,
    input wire logic tx_underflow_evt,
    input wire logic rx_overflow_evt,
    input wire logic tx_request_evt,
    input wire logic rx_ready_evt,
    input wire logic tx_channel_select,
    input wire logic rx_channel_indicator,
    input wire logic [iscd_pkg::DATA_W-1:0] rx_sample_high,
    input wire logic tx_buf_taken,
    output logic [iscd_pkg::DATA_W-1:0] tx_sample_high,
    output logic tx_buf_full,
    output logic rx_buf_empty,
    // Trigger sources
    input wire logic usb_sof,
    input wire logic trig_pin,
    input wire logic timer_event,
    // Clocking and interrupt
    output logic bit_tick,
    output logic bit_clk,
    output logic irq
);
    import iscd_pkg::*;

    // ----------------------------------------
    // Register state
    // ----------------------------------------
    logic [CNT_W-1:0] word_tally_r;
    logic [CNT_W-1:0] word_tally_nxt;
    logic [CNT_W-1:0] tally_cap_r;
    logic [CNT_W-1:0] tally_cap_nxt;
    logic tx_underflow_flag_r;
    logic tx_underflow_flag_nxt;
    logic rx_overflow_flag_r;
    logic rx_overflow_flag_nxt;
    logic tx_pending_flag_r;
    logic tx_pending_flag_nxt;
    logic rx_pending_flag_r;
    logic rx_pending_flag_nxt;
    iscd_trig_t capture_trigger_select_r;
    iscd_trig_t capture_trigger_select_nxt;
    logic [DEN_W-1:0] divider_denominator_r;
    logic [DEN_W-1:0] divider_denominator_nxt;
    logic [NUM_W-1:0] divider_numerator_r;
    logic [NUM_W-1:0] divider_numerator_nxt;
    logic [DATA_W-1:0] tx_high_r;
    logic [DATA_W-1:0] tx_high_nxt;
    logic tx_full_r;
    logic tx_full_nxt;
    logic rx_empty_r;
    logic rx_empty_nxt;
    logic [IRQ_W-1:0] irq_stat_r;
    logic [IRQ_W-1:0] irq_stat_nxt;
    logic [IRQ_W-1:0] irq_en_r;
    logic [IRQ_W-1:0] irq_en_nxt;
    logic [DATA_W-1:0] rdata_r;
    logic [DATA_W-1:0] rdata_nxt;

    // Pin synchroniser and edge detect
    logic pin_meta_r;
    logic pin_sync_r;
    logic pin_prev_r;
    logic pin_edge;

    // Decoded accesses
    logic wr_word_tally;
    logic wr_stat;
    logic wr_high;
    logic rd_high;
    logic hw_trigger;
    logic capture;
    logic [IRQ_W-1:0] irq_events;
    logic [DATA_W-1:0] status_word;

    // ----------------------------------------
    // Input synchronisation
    // ----------------------------------------
    // The first stage feeds only the second, keeping metastability contained
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pin_meta_r <= 1'b0;
            pin_sync_r <= 1'b0;
            pin_prev_r <= 1'b0;
        end else begin
            pin_meta_r <= trig_pin;
            pin_sync_r <= pin_meta_r;
            pin_prev_r <= pin_sync_r;
        end
    end

    assign pin_edge = pin_sync_r & ~pin_prev_r;

    // ----------------------------------------
    // Access decode and trigger selection
    // ----------------------------------------
    assign wr_word_tally = reg_wr && (reg_addr == ADDR_WORD_COUNT_LOW);
    assign wr_stat = reg_wr && (reg_addr == ADDR_STATUS);
    assign wr_high = reg_wr && (reg_addr == ADDR_SAMPLE_HIGH);
    assign rd_high = reg_rd && (reg_addr == ADDR_SAMPLE_HIGH);

    always_comb begin
        unique case (capture_trigger_select_r)
            ISCD_TRIG_REG: hw_trigger = 1'b0;
            ISCD_TRIG_SOF: hw_trigger = usb_sof;
            ISCD_TRIG_PIN: hw_trigger = pin_edge;
            ISCD_TRIG_TIMER: hw_trigger = timer_event;
        endcase
    end

    assign capture = wr_word_tally | hw_trigger;

    // ----------------------------------------
    // Word counter
    // ----------------------------------------
    always_comb begin
        word_tally_nxt = word_tally_r;
        tally_cap_nxt = tally_cap_r;
        if (word_done) begin
            word_tally_nxt = word_tally_r + CNT_W'(1);
        end
        if (capture) begin
            tally_cap_nxt = word_tally_r;
            // A word finishing on the trigger cycle opens the new interval
            word_tally_nxt = word_done ? CNT_W'(1) : '0;
        end
    end

    // ----------------------------------------
    // Status flags
    // ----------------------------------------
    // Hardware sets win over software clears so no event is lost
    always_comb begin
        tx_underflow_flag_nxt = tx_underflow_flag_r;
        rx_overflow_flag_nxt = rx_overflow_flag_r;
        tx_pending_flag_nxt = tx_pending_flag_r;
        rx_pending_flag_nxt = rx_pending_flag_r;
        if (wr_stat && !reg_wdata[ST_TX_UNF]) begin
            tx_underflow_flag_nxt = 1'b0;
        end
        if (tx_underflow_evt) begin
            tx_underflow_flag_nxt = 1'b1;
        end
        if (wr_stat && !reg_wdata[ST_RX_OVF]) begin
            rx_overflow_flag_nxt = 1'b0;
        end
        if (rx_overflow_evt) begin
            rx_overflow_flag_nxt = 1'b1;
        end
        if (wr_high) begin
            tx_pending_flag_nxt = 1'b0;
        end
        if (tx_request_evt || (wr_stat && reg_wdata[ST_TX_PEND])) begin
            tx_pending_flag_nxt = 1'b1;
        end
        if (rd_high) begin
            rx_pending_flag_nxt = 1'b0;
        end
        if (rx_ready_evt || (wr_stat && reg_wdata[ST_RX_PEND])) begin
            rx_pending_flag_nxt = 1'b1;
        end
    end

    // ----------------------------------------
    // Sample high byte and buffer state
    // ----------------------------------------
    always_comb begin
        tx_high_nxt = tx_high_r;
        tx_full_nxt = tx_full_r;
        rx_empty_nxt = rx_empty_r;
        if (tx_buf_taken) begin
            tx_full_nxt = 1'b0;
        end
        if (wr_high) begin
            tx_high_nxt = reg_wdata;
            tx_full_nxt = 1'b1;
        end
        if (rd_high) begin
            rx_empty_nxt = 1'b1;
        end
        // A sample landing on the read cycle must not be reported as gone
        if (rx_ready_evt) begin
            rx_empty_nxt = 1'b0;
        end
    end

    // ----------------------------------------
    // Configuration and interrupt registers
    // ----------------------------------------
    assign irq_events[IRQ_TX_UNF] = tx_underflow_evt;
    assign irq_events[IRQ_RX_OVF] = rx_overflow_evt;
    assign irq_events[IRQ_TX_PEND] = tx_request_evt;
    assign irq_events[IRQ_RX_PEND] = rx_ready_evt;
    assign irq_events[IRQ_CAPTURE] = capture;

    always_comb begin
        capture_trigger_select_nxt = capture_trigger_select_r;
        divider_denominator_nxt = divider_denominator_r;
        divider_numerator_nxt = divider_numerator_r;
        irq_en_nxt = irq_en_r;
        irq_stat_nxt = irq_stat_r;
        if (reg_wr) begin
            unique case (reg_addr)
                ADDR_TRIG_CFG: begin
                    capture_trigger_select_nxt = iscd_trig_t'(reg_wdata[TRIG_LSB +: 2]);
                end
                ADDR_DEN_LOW: begin
                    divider_denominator_nxt[DATA_W-1:0] = reg_wdata;
                end
                ADDR_NUM_LOW: begin
                    divider_numerator_nxt[DATA_W-1:0] = reg_wdata;
                end
                ADDR_DIV_HIGH: begin
                    divider_denominator_nxt[DEN_W-1] = reg_wdata[DIV_DEN_TOP];
                    divider_numerator_nxt[NUM_W-1:DATA_W] = reg_wdata[DIV_DEN_TOP-1:0];
                end
                ADDR_IRQ_ENABLE: begin
                    irq_en_nxt = reg_wdata[IRQ_W-1:0];
                end
                ADDR_IRQ_CLEAR: begin
                    irq_stat_nxt = irq_stat_r & ~reg_wdata[IRQ_W-1:0];
                end
                default: begin
                end
            endcase
        end
        irq_stat_nxt = irq_stat_nxt | irq_events;
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    // status word: software-writable flags plus read-only fields
    always_comb begin
        status_word = '0;
        status_word[ST_TX_UNF] = tx_underflow_flag_r;
        status_word[ST_RX_OVF] = rx_overflow_flag_r;
        status_word[ST_TX_CH] = tx_channel_select;
        status_word[ST_RX_CH] = rx_channel_indicator;
        status_word[ST_TX_PEND] = tx_pending_flag_r;
        status_word[ST_RX_PEND] = rx_pending_flag_r;
        status_word[ST_CNT_HI +: 2] = tally_cap_r[CNT_W-1:DATA_W];
    end

    // Data holds only in the cycle after the strobe; zero otherwise
    always_comb begin
        rdata_nxt = '0;
        if (reg_rd) begin
            unique case (reg_addr)
                ADDR_TRIG_CFG: rdata_nxt[TRIG_LSB +: 2] = capture_trigger_select_r;
                ADDR_SAMPLE_HIGH: rdata_nxt = rx_sample_high;
                ADDR_WORD_COUNT_LOW: rdata_nxt = tally_cap_r[DATA_W-1:0];
                ADDR_STATUS: rdata_nxt = status_word;
                ADDR_DEN_LOW: rdata_nxt = divider_denominator_r[DATA_W-1:0];
                ADDR_NUM_LOW: rdata_nxt = divider_numerator_r[DATA_W-1:0];
                ADDR_DIV_HIGH: begin
                    rdata_nxt = {divider_denominator_r[DEN_W-1],
                                 divider_numerator_r[NUM_W-1:DATA_W]};
                end
                ADDR_IRQ_STATUS: rdata_nxt[IRQ_W-1:0] = irq_stat_r;
                ADDR_IRQ_ENABLE: rdata_nxt[IRQ_W-1:0] = irq_en_r;
                default: rdata_nxt = '0;
            endcase
        end
    end

    // ----------------------------------------
    // State registers
    // ----------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            word_tally_r <= '0;
            tally_cap_r <= '0;
            tx_underflow_flag_r <= 1'b0;
            rx_overflow_flag_r <= 1'b0;
            tx_pending_flag_r <= 1'b0;
            rx_pending_flag_r <= 1'b0;
            capture_trigger_select_r <= ISCD_TRIG_REG;
            divider_denominator_r <= {RST_DEN_TOP, RST_DEN_LOW};
            divider_numerator_r <= {RST_NUM_HIGH, RST_NUM_LOW};
            tx_high_r <= '0;
            tx_full_r <= 1'b0;
            rx_empty_r <= 1'b1;
            irq_stat_r <= '0;
            irq_en_r <= '0;
            rdata_r <= '0;
        end else begin
            word_tally_r <= word_tally_nxt;
            tally_cap_r <= tally_cap_nxt;
            tx_underflow_flag_r <= tx_underflow_flag_nxt;
            rx_overflow_flag_r <= rx_overflow_flag_nxt;
            tx_pending_flag_r <= tx_pending_flag_nxt;
            rx_pending_flag_r <= rx_pending_flag_nxt;
            capture_trigger_select_r <= capture_trigger_select_nxt;
            divider_denominator_r <= divider_denominator_nxt;
            divider_numerator_r <= divider_numerator_nxt;
            tx_high_r <= tx_high_nxt;
            tx_full_r <= tx_full_nxt;
            rx_empty_r <= rx_empty_nxt;
            irq_stat_r <= irq_stat_nxt;
            irq_en_r <= irq_en_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // ----------------------------------------
    // Bit clock divider
    // ----------------------------------------
    // fractional bit clock
    iscd_frac_div #(
        .NUM_W(NUM_W),
        .DEN_W(DEN_W)
    ) u_div (
        .core_clk(core_clk),
        .rst(rst),
        .num(divider_numerator_r),
        .den(divider_denominator_r),
        .tick(bit_tick),
        .bit_clk(bit_clk)
    );

    assign reg_rdata = rdata_r;
    assign tx_sample_high = tx_high_r;
    assign tx_buf_full = tx_full_r;
    assign rx_buf_empty = rx_empty_r;
    assign irq = |(irq_stat_r & irq_en_r);
endmodule
`default_nettype wire

//--- sim/iscd_codec_model.sv
`timescale 1ns/1ps
`default_nettype none
module iscd_codec_model (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic tx_buf_full,
    output logic word_done,
    output logic tx_channel_select,
    output logic rx_channel_indicator,
    output logic [7:0] rx_sample_high,
    output logic tx_buf_taken
);
    // ----------------------------------------
    // Serial engine stand-in
    // ----------------------------------------
    int hold;
    initial begin
        word_done = 1'b0;
        tx_channel_select = 1'b0;
        rx_channel_indicator = 1'b0;
        rx_sample_high = 8'h5a;
        tx_buf_taken = 1'b0;
        hold = 0;
    end
    // Slow consumer: the byte sits a few cycles so the full flag can be seen
    always @(posedge core_clk) begin
        tx_buf_taken <= (hold == 3);
        hold <= (tx_buf_full && !tx_buf_taken && !rst) ? hold + 1 : 0;
    end
    task automatic send(input int n);
        repeat (n) begin
            @(posedge core_clk);
            word_done <= 1'b1;
            tx_channel_select <= ~tx_channel_select;
            rx_channel_indicator <= ~rx_channel_indicator;
            rx_sample_high <= rx_sample_high + 8'h35;
            @(posedge core_clk);
            word_done <= 1'b0;
        end
    endtask
endmodule
`default_nettype wire

//--- sim/iscd_props.sv
`timescale 1ns/1ps
`default_nettype none
module iscd_props
    import iscd_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [iscd_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [iscd_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [iscd_pkg::DATA_W-1:0] reg_rdata,
    input wire logic tx_underflow_evt,
    input wire logic rx_overflow_evt,
    input wire logic tx_request_evt,
    input wire logic rx_ready_evt,
    input wire logic tx_channel_select,
    input wire logic rx_channel_indicator,
    input wire logic [iscd_pkg::DATA_W-1:0] rx_sample_high,
    input wire logic tx_buf_taken,
    input wire logic [iscd_pkg::DATA_W-1:0] tx_sample_high,
    input wire logic tx_buf_full,
    input wire logic rx_buf_empty,
    input wire logic bit_tick,
    input wire logic bit_clk
);
    import iscd_pkg::*;
    // ----------------------------------------
    // Port relations
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    logic rd_st;
    logic rd_dh;
    logic wr_dh;
    assign rd_st = reg_rd && reg_addr == ADDR_STATUS;
    assign rd_dh = reg_rd && reg_addr == ADDR_SAMPLE_HIGH;
    assign wr_dh = reg_wr && reg_addr == ADDR_SAMPLE_HIGH;
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside answer cycle");
    a_unmapped_zero: assert property (reg_rd && reg_addr[15:8] != 8'hdf |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_unf_sticky: assert property (tx_underflow_evt ##1 rd_st |=> reg_rdata[ST_TX_UNF])
        else $error("underflow flag missing");
    a_ovf_sticky: assert property (rx_overflow_evt ##1 rd_st |=> reg_rdata[ST_RX_OVF])
        else $error("overflow flag missing");
    a_txch_live: assert property (rd_st |=> reg_rdata[5] == $past(tx_channel_select))
        else $error("tx channel bit wrong");
    a_rxch_live: assert property (rd_st |=> reg_rdata[4] == $past(rx_channel_indicator))
        else $error("rx channel bit wrong");
    a_txp_set: assert property (tx_request_evt ##1 rd_st |=> reg_rdata[ST_TX_PEND])
        else $error("tx pending missing");
    a_txp_clear: assert property (wr_dh && !tx_request_evt ##1 rd_st && !tx_request_evt
        |=> !reg_rdata[ST_TX_PEND])
        else $error("tx pending not cleared");
    a_rxp_clear: assert property (rd_dh && !rx_ready_evt ##1 rd_st && !rx_ready_evt
        |=> !reg_rdata[ST_RX_PEND])
        else $error("rx pending not cleared");
    a_rx_empty: assert property (rd_dh && !rx_ready_evt |=> rx_buf_empty)
        else $error("rx buffer not empty");
    a_tx_full: assert property (wr_dh && !tx_buf_taken
        |=> tx_buf_full && tx_sample_high == $past(reg_wdata))
        else $error("tx buffer not loaded");
    a_rd_sample: assert property (rd_dh |=> reg_rdata == $past(rx_sample_high))
        else $error("sample read wrong");
    a_clk_follow: assert property ($changed(bit_clk) |-> bit_tick || $past(bit_tick))
        else $error("bit clock moved without tick");
    c_rd_st: cover property (rd_st);
    c_wr_dh: cover property (wr_dh);
    c_tick: cover property (bit_tick);
endmodule
bind iscd_top iscd_props i_props (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .tx_underflow_evt, .rx_overflow_evt, .tx_request_evt, .rx_ready_evt,
    .tx_channel_select, .rx_channel_indicator, .rx_sample_high, .tx_buf_taken,
    .tx_sample_high, .tx_buf_full, .rx_buf_empty, .bit_tick, .bit_clk);
`default_nettype wire

//--- sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import iscd_pkg::*;
    // ----------------------------------------
    // Bench
    // ----------------------------------------
    logic core_clk, rst, reg_wr, reg_rd, word_done, tx_channel_select, rx_channel_indicator;
    logic tx_buf_taken, tx_buf_full, rx_buf_empty, bit_tick, bit_clk, irq;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata, tx_sample_high, rx_sample_high, d, d1;
    logic [6:0] evts;
    logic unf, ovf, txp, rxp, pclk;
    logic [9:0] cap;
    int fails, samples_checked, seed, n, m;
    iscd_top i_dut (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .word_done, .tx_underflow_evt(evts[0]), .rx_overflow_evt(evts[1]),
        .tx_request_evt(evts[2]), .rx_ready_evt(evts[3]), .tx_channel_select,
        .rx_channel_indicator, .rx_sample_high, .tx_buf_taken, .tx_sample_high, .tx_buf_full,
        .rx_buf_empty, .usb_sof(evts[4]), .trig_pin(evts[5]), .timer_event(evts[6]),
        .bit_tick, .bit_clk, .irq);
    iscd_codec_model codec (.core_clk, .rst, .tx_buf_full, .word_done, .tx_channel_select,
        .rx_channel_indicator, .rx_sample_high, .tx_buf_taken);
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    // Write or read at a, then a read of b with no idle cycle between
    task automatic pair(input logic w, input logic [15:0] a, input logic [7:0] v,
        input logic [15:0] b);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= w;
        reg_rd <= !w;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_addr <= b;
        reg_rd <= 1'b1;
        #1;
        d1 = reg_rdata;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    task automatic ev(input int k);
        @(posedge core_clk);
        evts[k] <= 1'b1;
        @(posedge core_clk);
        evts[k] <= 1'b0;
    endtask
    task automatic chk(input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    function automatic logic [7:0] st_exp();
        return {unf, ovf, tx_channel_select, rx_channel_indicator, txp, rxp, cap[9:8]};
    endfunction
    task automatic complete_run();
        $display("fails=%0d samples_checked=%0d", fails, samples_checked);
        if (fails == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    initial begin
        #2000000;
        fails++;
        complete_run();
    end
    initial begin
        seed = 32'ha737;
        {rst, reg_wr, reg_rd, evts, reg_addr, reg_wdata} = '0;
        rst = 1'b1;
        {fails, samples_checked} = '0;
        {unf, ovf, txp, rxp, cap} = '0;
        repeat (12) @(posedge core_clk);
        chk(8'h01, {6'h00, tx_buf_full, rx_buf_empty});
        rst <= 1'b0;
        rd(ADDR_DEN_LOW); chk(8'h93, d);
        rd(ADDR_NUM_LOW); chk(8'he2, d);
        rd(ADDR_DIV_HIGH); chk(8'h04, d);
        rd(ADDR_WORD_COUNT_LOW); chk(8'h00, d);
        rd(ADDR_STATUS); chk(st_exp(), d);
        rd(16'h1234); chk(8'h00, d);
        // Denominator 256 over numerator 2560 gives one tick in ten cycles
        wr(ADDR_DEN_LOW, 8'h00);
        wr(ADDR_NUM_LOW, 8'h00);
        wr(ADDR_DIV_HIGH, 8'h8a);
        rd(ADDR_DIV_HIGH); chk(8'h8a, d);
        n = 0;
        m = 0;
        pclk = bit_clk;
        repeat (1000) begin
            @(posedge core_clk);
            #1;
            n += bit_tick;
            m += (bit_clk != pclk);
            pclk = bit_clk;
        end
        // Accumulator phase is unknown, so one tick either way is accepted
        chk(8'd100, (n >= 99 && n <= 101) ? 8'd100 : 8'(n));
        chk(8'd100, (m >= 99 && m <= 101) ? 8'd100 : 8'(m));
        for (int s = 0; s < 4; s++) begin
            wr(ADDR_TRIG_CFG, 8'(s << TRIG_LSB));
            wr(ADDR_WORD_COUNT_LOW, 8'($random(seed)));
            n = (s == 0) ? 1030 : 200 + ($random(seed) & 255);
            codec.send(n);
            repeat (2) @(posedge core_clk);
            if (s == 0) begin
                wr(ADDR_WORD_COUNT_LOW, 8'($random(seed)));
            end else begin
                ev(s + 3);
            end
            repeat (4) @(posedge core_clk);
            cap = 10'(n % 1024);
            rd(ADDR_WORD_COUNT_LOW); chk(cap[7:0], d);
            rd(ADDR_STATUS); chk(st_exp(), d);
        end
        wr(ADDR_IRQ_CLEAR, 8'hff);
        wr(ADDR_IRQ_ENABLE, 8'h01);
        // All four events in one cycle, status read in the very next one
        @(posedge core_clk);
        evts[3:0] <= 4'hf;
        @(posedge core_clk);
        evts[3:0] <= 4'h0;
        reg_addr <= ADDR_STATUS;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        {unf, ovf, txp, rxp} = 4'hf;
        chk(st_exp(), reg_rdata);
        chk(8'h01, 8'(irq));
        chk(8'h00, 8'(rx_buf_empty));
        rd(ADDR_STATUS); chk(st_exp(), d);
        rd(ADDR_IRQ_STATUS); chk(8'h0f, d);
        wr(ADDR_IRQ_ENABLE, 8'h02);
        wr(ADDR_IRQ_CLEAR, 8'h02);
        wr(ADDR_IRQ_STATUS, 8'h00);
        #1;
        chk(8'h00, 8'(irq));
        rd(ADDR_IRQ_STATUS); chk(8'h0d, d);
        wr(ADDR_STATUS, 8'h3f);
        {unf, ovf} = 2'b00;
        rd(ADDR_STATUS); chk(st_exp(), d);
        pair(1'b1, ADDR_SAMPLE_HIGH, 8'hc4, ADDR_STATUS);
        txp = 1'b0;
        chk(st_exp(), d);
        chk(8'hc4, tx_sample_high);
        chk(8'h01, 8'(tx_buf_full));
        pair(1'b0, ADDR_SAMPLE_HIGH, 8'h00, ADDR_STATUS);
        chk(rx_sample_high, d1);
        rxp = 1'b0;
        chk(8'h01, 8'(rx_buf_empty));
        chk(st_exp(), d);
        wr(ADDR_STATUS, 8'h0c);
        {txp, rxp} = 2'b11;
        rd(ADDR_STATUS); chk(st_exp(), d);
        chk(8'h00, 8'(tx_buf_full));
        complete_run();
    end
endmodule
`default_nettype wire
